// >>> logic/ldors_pkg.sv
// ***************************************************************
// Shared constants and types for the rail state control bank
// ***************************************************************
package ldors_pkg;
	localparam int NUM_RAILS = 2;
	localparam int REG_W = 8;
	localparam int FIELD_W = 3;

	// Register addresses, as seen on the parallel register port
	localparam logic [REG_W-1:0] ADDR_RAIL_A = 8'h3d;
	localparam logic [REG_W-1:0] ADDR_RAIL_B = 8'h3e;
	localparam logic [NUM_RAILS-1:0][REG_W-1:0] RAIL_ADDR = {ADDR_RAIL_B, ADDR_RAIL_A};

	// Reset values: rail a active with no exit copy, rail b off with active on exit
	localparam logic [REG_W-1:0] RST_RAIL_A = 8'h07;
	localparam logic [REG_W-1:0] RST_RAIL_B = 8'h3c;
	localparam logic [NUM_RAILS-1:0][REG_W-1:0] RAIL_RST = {RST_RAIL_B, RST_RAIL_A};

	// Field layout
	localparam int NORM_LSB = 0;
	localparam int EXIT_LSB = 3;
	localparam logic [REG_W-1:0] WRITE_MASK = 8'h3f;
	localparam int VALID_BIT = 2;

	// State codes of a field
	localparam logic [FIELD_W-1:0] CODE_OFF = 3'h4;
	localparam logic [FIELD_W-1:0] CODE_LOW = 3'h5;

	typedef enum logic [1:0] {
		LDORS_OFF = 2'b00,
		LDORS_LOW = 2'b01,
		LDORS_ACT = 2'b10
	} ldors_state_t;

	typedef struct packed {
		ldors_state_t state;
		logic discharge_en;
		logic over_current;
		logic under_voltage;
	} ldors_rail_t;
endpackage

// >>> logic/ldors_ctrl.sv
`timescale 1ns/10ps
module ldors_ctrl #(
	parameter int NUM_RAILS = ldors_pkg::NUM_RAILS
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [ldors_pkg::REG_W-1:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [ldors_pkg::REG_W-1:0] reg_wdata,
	input wire logic reg_rd_en,
	output logic [ldors_pkg::REG_W-1:0] reg_rdata,
	input wire logic standby_exit_pin,
	input wire logic [NUM_RAILS-1:0] oc_det,
	input wire logic [NUM_RAILS-1:0] uv_det,
	output ldors_pkg::ldors_rail_t [NUM_RAILS-1:0] rail_out
);
	// ***************************************************************
	// Storage
	// ***************************************************************
	logic [NUM_RAILS-1:0][ldors_pkg::REG_W-1:0] ctl_r;
	logic [NUM_RAILS-1:0][ldors_pkg::REG_W-1:0] ctl_nxt;
	logic [ldors_pkg::REG_W-1:0] rdata_r;
	logic [ldors_pkg::REG_W-1:0] rdata_nxt;
	logic exit_prev_r;
	logic exit_prev_nxt;
	logic exit_rise;
	ldors_pkg::ldors_rail_t [NUM_RAILS-1:0] rail_r;
	ldors_pkg::ldors_rail_t [NUM_RAILS-1:0] rail_nxt;
	// Reset shows every rail off with discharge on, so the off and discharge pairing holds in reset too
	localparam ldors_pkg::ldors_rail_t RAIL_IDLE = '{
		state: ldors_pkg::LDORS_OFF,
		discharge_en: 1'b1,
		over_current: 1'b0,
		under_voltage: 1'b0
	};

	// Rising edge of the exit pin; a held pin copies only once
	assign exit_rise = standby_exit_pin & ~exit_prev_r;
	assign exit_prev_nxt = standby_exit_pin;

	// ***************************************************************
	// Register write and exit copy
	// ***************************************************************
	// Copy is applied after the write so a pin edge wins over a same-cycle write of the normal field
	always_comb begin
		logic [ldors_pkg::REG_W-1:0] wval;
		logic [ldors_pkg::FIELD_W-1:0] exit_f;
		wval = '0;
		exit_f = '0;
		for (int i = 0; i < NUM_RAILS; i++) begin
			ctl_nxt[i] = ctl_r[i];
			exit_f = ctl_r[i][ldors_pkg::EXIT_LSB +: ldors_pkg::FIELD_W];
			if (reg_wr_en && reg_addr == ldors_pkg::RAIL_ADDR[i]) begin
				wval = reg_wdata & ldors_pkg::WRITE_MASK; // Reserved top bits stay zero
				// Reserved normal codes are refused; the rail keeps its state
				if (!wval[ldors_pkg::NORM_LSB + ldors_pkg::VALID_BIT]) begin
					wval[ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W] =
						ctl_r[i][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W];
				end
				ctl_nxt[i] = wval;
			end
			if (exit_rise && exit_f[ldors_pkg::VALID_BIT]) begin
				ctl_nxt[i][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W] = exit_f;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_r <= ldors_pkg::RAIL_RST;
			exit_prev_r <= 1'b0;
		end else begin
			ctl_r <= ctl_nxt;
			exit_prev_r <= exit_prev_nxt;
		end
	end

	// ***************************************************************
	// Read path
	// ***************************************************************
	// Data appears one cycle after the read strobe; unmapped addresses read zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_en) begin
			rdata_nxt = '0;
			for (int i = 0; i < NUM_RAILS; i++) begin
				if (reg_addr == ldors_pkg::RAIL_ADDR[i]) begin
					rdata_nxt = ctl_r[i];
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// ***************************************************************
	// Rail state decode and monitors
	// ***************************************************************
	// Reserved codes can never be stored, so they fall to the active branch only in theory
	always_comb begin
		logic [ldors_pkg::FIELD_W-1:0] norm_f;
		norm_f = '0;
		for (int i = 0; i < NUM_RAILS; i++) begin
			norm_f = ctl_r[i][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W];
			case (norm_f)
				ldors_pkg::CODE_OFF: begin
					rail_nxt[i].state = ldors_pkg::LDORS_OFF;
				end
				ldors_pkg::CODE_LOW: begin
					rail_nxt[i].state = ldors_pkg::LDORS_LOW;
				end
				default: begin
					rail_nxt[i].state = ldors_pkg::LDORS_ACT;
				end
			endcase
			rail_nxt[i].discharge_en = (norm_f == ldors_pkg::CODE_OFF);
			rail_nxt[i].over_current = oc_det[i];
			rail_nxt[i].under_voltage = uv_det[i];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rail_r <= {NUM_RAILS{RAIL_IDLE}}; // Off with discharge on until the first edge decodes the reset values
		end else begin
			rail_r <= rail_nxt;
		end
	end

	assign rail_out = rail_r;

	// ***************************************************************
	// Checks
	// ***************************************************************
	// Both registers hold their reset values at the first edge after release
	a_reset_rail_a: assert property (@(posedge core_clk) $rose(nrst) |-> ctl_r[0] == ldors_pkg::RST_RAIL_A)
		else $error("Rail a register not at reset value");
	a_reset_rail_b: assert property (@(posedge core_clk) $rose(nrst) |-> ctl_r[1] == ldors_pkg::RST_RAIL_B)
		else $error("Rail b register not at reset value");
	// An address that no rail owns reads as zero
	a_read_unmapped: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_rd_en && reg_addr != ldors_pkg::RAIL_ADDR[0] && reg_addr != ldors_pkg::RAIL_ADDR[1]
		|=> reg_rdata == '0)
		else $error("Unmapped read not zero");

	// Per-rail checks; each rail is judged on its own register only
	for (genvar g = 0; g < NUM_RAILS; g++) begin : g_chk
		a_off_decode: assert property (@(posedge core_clk) disable iff (!nrst)
			ctl_r[g][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W] == ldors_pkg::CODE_OFF
			|=> rail_out[g].state == ldors_pkg::LDORS_OFF)
			else $error("Off code not decoded");
		a_low_decode: assert property (@(posedge core_clk) disable iff (!nrst)
			ctl_r[g][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W] == ldors_pkg::CODE_LOW
			|=> rail_out[g].state == ldors_pkg::LDORS_LOW)
			else $error("Low power code not decoded");
		a_exit_copy: assert property (@(posedge core_clk) disable iff (!nrst)
			exit_rise && ctl_r[g][ldors_pkg::EXIT_LSB + ldors_pkg::VALID_BIT]
			|=> ctl_r[g][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W] ==
				$past(ctl_r[g][ldors_pkg::EXIT_LSB +: ldors_pkg::FIELD_W]) ##1
				rail_out[g].discharge_en ==
				($past(ctl_r[g][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W]) == ldors_pkg::CODE_OFF))
			else $error("Exit state not copied");
		// A held pin or a do-not-copy field must leave the register alone
		a_exit_nocopy: assert property (@(posedge core_clk) disable iff (!nrst)
			(standby_exit_pin && !exit_rise || !ctl_r[g][ldors_pkg::EXIT_LSB + ldors_pkg::VALID_BIT])
			&& !(reg_wr_en && reg_addr == ldors_pkg::RAIL_ADDR[g])
			|=> $stable(ctl_r[g]))
			else $error("Normal state changed without edge or write");
		a_no_cross: assert property (@(posedge core_clk) disable iff (!nrst)
			reg_wr_en && reg_addr != ldors_pkg::RAIL_ADDR[g] && !exit_rise
			|=> $stable(ctl_r[g]))
			else $error("Write to another address changed this rail");
		a_discharge: assert property (@(posedge core_clk) disable iff (!nrst)
			rail_out[g].discharge_en == (rail_out[g].state == ldors_pkg::LDORS_OFF))
			else $error("Discharge does not follow off state");
		// Flags are level followers with one edge of delay, never sticky
		a_fault_flags: assert property (@(posedge core_clk) disable iff (!nrst)
			##1 (rail_out[g].over_current == $past(oc_det[g]) && rail_out[g].under_voltage == $past(uv_det[g])))
			else $error("Fault flags do not follow monitors");
		// Codes 6 and 7 both run the rail at full power; the release edge is skipped
		a_act_decode: assert property (@(posedge core_clk) disable iff (!nrst)
			nrst && ctl_r[g][ldors_pkg::NORM_LSB + ldors_pkg::VALID_BIT]
			&& ctl_r[g][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W] != ldors_pkg::CODE_OFF
			&& ctl_r[g][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W] != ldors_pkg::CODE_LOW
			|=> rail_out[g].state == ldors_pkg::LDORS_ACT)
			else $error("Active code not decoded");
		// A reserved normal code in a write leaves the running state alone
		a_reserved_keep: assert property (@(posedge core_clk) disable iff (!nrst)
			reg_wr_en && reg_addr == ldors_pkg::RAIL_ADDR[g] && !exit_rise
			&& !reg_wdata[ldors_pkg::NORM_LSB + ldors_pkg::VALID_BIT]
			|=> ctl_r[g][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W] ==
				$past(ctl_r[g][ldors_pkg::NORM_LSB +: ldors_pkg::FIELD_W]))
			else $error("Reserved normal code was stored");
		// A write with a valid normal code lands whole, top bits cleared
		a_write_lands: assert property (@(posedge core_clk) disable iff (!nrst)
			reg_wr_en && reg_addr == ldors_pkg::RAIL_ADDR[g] && !exit_rise
			&& reg_wdata[ldors_pkg::NORM_LSB + ldors_pkg::VALID_BIT]
			|=> ctl_r[g] == $past(reg_wdata & ldors_pkg::WRITE_MASK))
			else $error("Register write did not land");
		// The two top bits are never stored
		a_top_bits: assert property (@(posedge core_clk) disable iff (!nrst)
			ctl_r[g][ldors_pkg::REG_W-1:ldors_pkg::EXIT_LSB + ldors_pkg::FIELD_W] == '0)
			else $error("Reserved top bits set");
		// Read data is the register as it stood at the strobe edge
		a_read_back: assert property (@(posedge core_clk) disable iff (!nrst)
			reg_rd_en && reg_addr == ldors_pkg::RAIL_ADDR[g]
			|=> reg_rdata == $past(ctl_r[g]))
			else $error("Read data differs from register");
	end
endmodule // ldors_ctrl

// >>> tb/ldors_host.sv
`timescale 1ns/10ps
// *****
// Host controller stand-in
// *****
module ldors_host (
	input wire logic core_clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic [7:0] reg_wdata,
	output logic reg_rd_en
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
	end
	// One-cycle write; data scrambled after so no stale byte is trusted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// One-cycle read, data taken once it has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		@(posedge core_clk);
		#1;
		d = reg_rdata;
	endtask
endmodule // ldors_host

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
	logic core_clk, nrst, standby_exit_pin;
	logic [1:0] oc_det, uv_det;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr_en, reg_rd_en;
	ldors_pkg::ldors_rail_t [1:0] rail_out;
	int n_fail, cmp_count;
	ldors_ctrl ldors_ctrl_i (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .standby_exit_pin(standby_exit_pin),
		.oc_det(oc_det), .uv_det(uv_det), .rail_out(rail_out));
	ldors_host ldors_host_i (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));
	// *****
	// Helpers
	// *****
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
		ldors_host_i.rd(a, d);
		chk(d, exp);
	endtask
	// Rail word is state, discharge, over-current, under-voltage
	task automatic rail_is(input int i, input logic [4:0] exp);
		chk({3'h0, rail_out[i]}, {3'h0, exp});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic pin(input logic v);
		@(posedge core_clk);
		standby_exit_pin <= v;
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// *****
	// Scenarios
	// *****
	task automatic t_reset;
		rail_is(0, 5'h10);
		rail_is(1, 5'h04);
		reg_is(8'h3d, 8'h07);
		reg_is(8'h3e, 8'h3c);
		reg_is(8'h40, 8'h00);
	endtask
	// Reserved normal code must not disturb the running state
	task automatic t_write;
		ldors_host_i.wr(8'h3e, 8'h25);
		settle(2);
		rail_is(1, 5'h08);
		rail_is(0, 5'h10);
		ldors_host_i.wr(8'h3e, 8'hea);
		reg_is(8'h3e, 8'h2d);
		ldors_host_i.wr(8'h3f, 8'hff);
		reg_is(8'h3d, 8'h07);
	endtask
	task automatic t_exit;
		ldors_host_i.wr(8'h3d, 8'h26);
		ldors_host_i.wr(8'h3e, 8'h0e);
		pin(1'b1);
		settle(3);
		rail_is(0, 5'h04);
		reg_is(8'h3d, 8'h24);
		reg_is(8'h3e, 8'h0e);
		ldors_host_i.wr(8'h3d, 8'h26);
		settle(3);
		reg_is(8'h3d, 8'h26);
		pin(1'b0);
		pin(1'b1);
		settle(3);
		reg_is(8'h3d, 8'h24);
		pin(1'b0);
	endtask
	// Flags follow the monitors and do not stick
	task automatic t_mon;
		@(posedge core_clk);
		oc_det <= 2'b01;
		uv_det <= 2'b10;
		settle(2);
		rail_is(0, 5'h06);
		rail_is(1, 5'h11);
		@(posedge core_clk);
		oc_det <= 2'b00;
		uv_det <= 2'b00;
		settle(2);
		rail_is(0, 5'h04);
	endtask
	// Low power is copied on rail a and the upper active code on rail b
	task automatic t_copy;
		ldors_host_i.wr(8'h3d, 8'h2c);
		ldors_host_i.wr(8'h3e, 8'h3c);
		pin(1'b1);
		settle(3);
		reg_is(8'h3d, 8'h2d);
		reg_is(8'h3e, 8'h3f);
		rail_is(0, 5'h08);
		rail_is(1, 5'h10);
		pin(1'b0);
	endtask
	// Reset in mid-run brings back the reset values and clears the read data
	task automatic t_rst2;
		@(posedge core_clk);
		nrst <= 1'b0;
		settle(1);
		chk(reg_rdata, 8'h00);
		rail_is(0, 5'h04);
		rail_is(1, 5'h04);
		@(posedge core_clk);
		nrst <= 1'b1;
		settle(1);
		rail_is(0, 5'h10);
		rail_is(1, 5'h04);
		reg_is(8'h3d, 8'h07);
		reg_is(8'h3e, 8'h3c);
	endtask
	// Free-running clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Watchdog well beyond the fewer than one hundred cycles the run needs
	initial begin
		#20000;
		n_fail++;
		give_verdict;
	end
	initial begin
		nrst = 1'b0;
		standby_exit_pin = 1'b0;
		oc_det = 2'b00;
		uv_det = 2'b00;
		n_fail = 0;
		cmp_count = 0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		settle(1);
		t_reset;
		t_write;
		t_exit;
		t_mon;
		t_copy;
		t_rst2;
		give_verdict;
	end
endmodule // tb
